/* File: btu_pkg.sv */
// Package for the breakpoint and tag unit: register map, fields, types
package btu_pkg;
	// Register indices (byte address = 4 * index)
	localparam logic [7:0] IDX_CTRL_PRIMARY = 8'h20;
	localparam logic [7:0] IDX_CTRL_SECONDARY = 8'h21;
	localparam logic [7:0] IDX_ADDR_HIGH = 8'h22;
	localparam logic [7:0] IDX_ADDR_LOW = 8'h23;
	localparam logic [7:0] IDX_CMP_HIGH = 8'h24;
	localparam logic [7:0] IDX_CMP_LOW = 8'h25;
	localparam logic [7:0] IDX_STATUS = 8'h26;
	localparam int BUS_ADDR_W = 10;
	// Primary control fields
	localparam int F_MODE_HI = 7;
	localparam int F_MODE_LO = 6;
	localparam int F_PROG_ONLY = 5;
	localparam int F_SECOND_LBE = 1;
	localparam int F_FIRST_LBE = 0;
	// Secondary control fields
	localparam int F_DATA_EN = 7;
	localparam int F_HIGH_MASK = 6;
	localparam int F_LOW_MASK = 5;
	localparam int F_SECOND_DIR_EN = 3;
	localparam int F_SECOND_DIR_VAL = 2;
	localparam int F_FIRST_DIR_EN = 1;
	localparam int F_FIRST_DIR_VAL = 0;
	// Status fields
	localparam int F_ST_TAGGING = 0;
	localparam int F_ST_BDM = 1;
	localparam int F_ST_HIT = 2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_SWI_DUAL = 2'h1;
	localparam logic [1:0] MODE_BDM_FULL = 2'h2;
	localparam logic [1:0] MODE_BDM_DUAL = 2'h3;
	localparam int QUEUE_DEPTH = 3;

	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
		logic rd;
		logic valid;
		logic fetch;
	} btu_cycle_s;

	typedef struct packed {
		logic [15:0] bytes;
		logic tag_hi;
		logic tag_lo;
	} btu_qword_s;
endpackage

/* File: btu_top.sv */
// Breakpoint comparator and instruction tagging unit with Avalon-MM registers
`timescale 1ns/100ps
`default_nettype none

module btu_top
	import btu_pkg::*;
(
	input wire logic clk_sys, // System clock, 25 MHz
	input wire logic rst, // Asynchronous reset, active high
	input wire logic clk_en, // Freezes all state when low
	input wire logic [BUS_ADDR_W-1:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [31:0] avs_writedata, // Write data
	input wire logic [3:0] avs_byteenable, // Byte lanes
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Stall
	input wire btu_cycle_s cpu_cycle, // CPU bus cycle observed
	input wire logic bus_clock, // Bus clock pin, foreign domain
	input wire logic low_strobe_n, // Low strobe / low tag pin
	input wire logic debug_serial_pin, // Debug pin / high tag pin
	input wire logic tagging_enable_command, // One-cycle tag command pulse
	input wire logic bdm_enable, // Debug enable indication
	input wire logic bdm_active, // CPU runs debug firmware
	input wire logic queue_load, // Fetch bytes enter queue tail
	input wire logic queue_advance, // Queue head consumed
	output logic swi_request, // Software interrupt request pulse
	output logic bdm_request, // Debug entry request pulse
	output logic tagging_active, // Tag pins in use
	output logic serial_cmd_allow // Serial commands may run
);
	logic [7:0] ctrl_primary_q;
	logic [7:0] ctrl_secondary_q;
	logic [7:0] addr_high_q;
	logic [7:0] addr_low_q;
	logic [7:0] cmp_high_q;
	logic [7:0] cmp_low_q;
	logic hit_seen_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic [1:0] mode;
	logic prog_only;
	logic data_en;
	logic match0;
	logic match1;
	logic cycle_hit;
	logic tag_break;
	logic bp_break;
	logic bp_tag_in;
	logic boundary_pend_q;
	logic swi_q;
	logic bdm_q;
	logic [2:0] ck_sync_q;
	logic [2:0] tlo_sync_q;
	logic [2:0] thi_sync_q;
	logic ck_stable_q;
	logic tlo_stable_q;
	logic thi_stable_q;
	logic ck_fall;
	logic tag_lo_q;
	logic tag_hi_q;
	logic tagging_q;
	btu_qword_s queue_q [QUEUE_DEPTH];
	logic bp_tag_q [QUEUE_DEPTH];
	logic [1:0] queue_count_q;
	logic [7:0] reg_index;
	logic req;

	function automatic logic byte_eq(input logic [7:0] a, input logic [7:0] b);
		byte_eq = (a == b);
	endfunction

	function automatic logic dir_ok(input logic en, input logic val, input logic rd);
		dir_ok = !en || (val == rd);
	endfunction

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
		input logic be);
		merge = be ? nw : old;
	endfunction

	function automatic btu_qword_s qword(input logic [15:0] b, input logic hi,
		input logic lo);
		qword = '{bytes: b, tag_hi: hi, tag_lo: lo};
	endfunction

	assign mode = {ctrl_primary_q[F_MODE_HI], ctrl_primary_q[F_MODE_LO]};
	assign prog_only = ctrl_primary_q[F_PROG_ONLY];
	assign data_en = ctrl_secondary_q[F_DATA_EN];
	assign reg_index = avs_address[BUS_ADDR_W-1:2];
	assign req = avs_read || avs_write;
	// Breakpoint tag carried by a fetch; kept apart from the pin tags
	assign bp_tag_in = cycle_hit && (prog_only || mode == MODE_SWI_DUAL)
		&& cpu_cycle.fetch;

	// Register bus: one wait cycle, then answer
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ack_q <= 1'b0;
		else if (clk_en)
			ack_q <= req && !ack_q;
	end
	assign avs_waitrequest = req && !ack_q;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctrl_primary_q <= REG_RESET;
			ctrl_secondary_q <= REG_RESET;
			addr_high_q <= REG_RESET;
			addr_low_q <= REG_RESET;
			cmp_high_q <= REG_RESET;
			cmp_low_q <= REG_RESET;
		end
		else if (clk_en && avs_write && ack_q)
		begin
			unique case (reg_index)
				IDX_CTRL_PRIMARY: ctrl_primary_q <= merge(ctrl_primary_q,
					avs_writedata[7:0], avs_byteenable[0]);
				IDX_CTRL_SECONDARY: ctrl_secondary_q <= merge(ctrl_secondary_q,
					avs_writedata[7:0], avs_byteenable[0]);
				IDX_ADDR_HIGH: addr_high_q <= merge(addr_high_q, avs_writedata[7:0],
					avs_byteenable[0]);
				IDX_ADDR_LOW: addr_low_q <= merge(addr_low_q, avs_writedata[7:0],
					avs_byteenable[0]);
				IDX_CMP_HIGH: cmp_high_q <= merge(cmp_high_q, avs_writedata[7:0],
					avs_byteenable[0]);
				IDX_CMP_LOW: cmp_low_q <= merge(cmp_low_q, avs_writedata[7:0],
					avs_byteenable[0]);
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rdata_q <= 32'h0000_0000;
		else if (clk_en && avs_read && !ack_q)
		begin
			unique case (reg_index)
				IDX_CTRL_PRIMARY: rdata_q <= {24'h000000, ctrl_primary_q};
				IDX_CTRL_SECONDARY: rdata_q <= {24'h000000, ctrl_secondary_q};
				IDX_ADDR_HIGH: rdata_q <= {24'h000000, addr_high_q};
				IDX_ADDR_LOW: rdata_q <= {24'h000000, addr_low_q};
				IDX_CMP_HIGH: rdata_q <= {24'h000000, cmp_high_q};
				IDX_CMP_LOW: rdata_q <= {24'h000000, cmp_low_q};
				IDX_STATUS: rdata_q <= {29'h0, hit_seen_q, bdm_active, tagging_q};
				default: rdata_q <= 32'h0000_0000;
			endcase
		end
	end
	assign avs_readdata = rdata_q;

	// Comparators
	always_comb
	begin
		match0 = cpu_cycle.valid && byte_eq(cpu_cycle.addr[15:8], addr_high_q)
			&& (!ctrl_primary_q[F_FIRST_LBE]
			|| byte_eq(cpu_cycle.addr[7:0], addr_low_q));
		if (mode == MODE_BDM_FULL)
		begin
			match0 = match0 && dir_ok(ctrl_secondary_q[F_FIRST_DIR_EN],
				ctrl_secondary_q[F_FIRST_DIR_VAL], cpu_cycle.rd);
			if (data_en)
				match0 = match0
					&& (ctrl_secondary_q[F_HIGH_MASK]
					|| byte_eq(cpu_cycle.data[15:8], cmp_high_q))
					&& (ctrl_secondary_q[F_LOW_MASK]
					|| byte_eq(cpu_cycle.data[7:0], cmp_low_q));
			match1 = 1'b0;
		end
		else
		begin
			match1 = cpu_cycle.valid && data_en
				&& byte_eq(cpu_cycle.addr[15:8], cmp_high_q)
				&& (!ctrl_primary_q[F_SECOND_LBE]
				|| byte_eq(cpu_cycle.addr[7:0], cmp_low_q));
			if (mode == MODE_BDM_DUAL)
			begin
				match0 = match0 && dir_ok(ctrl_secondary_q[F_FIRST_DIR_EN],
					ctrl_secondary_q[F_FIRST_DIR_VAL], cpu_cycle.rd);
				match1 = match1 && dir_ok(ctrl_secondary_q[F_SECOND_DIR_EN],
					ctrl_secondary_q[F_SECOND_DIR_VAL], cpu_cycle.rd);
			end
		end
		cycle_hit = (match0 || match1) && (mode != MODE_OFF) && !bdm_active;
	end

	// Break on cycle match: held pending until the next boundary (when the queue advances)
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			boundary_pend_q <= 1'b0;
		else if (clk_en)
		begin
			if (bdm_active || mode == MODE_OFF)
				boundary_pend_q <= 1'b0;
			else if (cycle_hit && !prog_only && mode != MODE_SWI_DUAL)
				boundary_pend_q <= 1'b1;
			else if (queue_advance)
				boundary_pend_q <= 1'b0;
		end
	end

	// Request pulses
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			swi_q <= 1'b0;
			bdm_q <= 1'b0;
			hit_seen_q <= 1'b0;
		end
		else if (clk_en)
		begin
			swi_q <= 1'b0;
			bdm_q <= 1'b0;
			if (!bdm_active)
			begin
				// A pin tag at the head means debug entry when bdm_enable is set, even in interrupt mode
				if (queue_advance && bp_break && !tag_break && mode == MODE_SWI_DUAL)
					swi_q <= 1'b1;
				else if (queue_advance && bdm_enable && (tag_break
					|| ((mode == MODE_BDM_FULL || mode == MODE_BDM_DUAL)
					&& (boundary_pend_q || bp_break))))
					bdm_q <= 1'b1;
			end
			if (swi_q || bdm_q)
				hit_seen_q <= 1'b1;
			else if (clk_en && avs_read && ack_q && reg_index == IDX_STATUS)
				hit_seen_q <= 1'b0;
		end
	end
	assign swi_request = swi_q;
	assign bdm_request = bdm_q;

	// Pin synchronisers: change accepted when stages two and three agree
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			// Idle high levels, so that no false edge follows reset
			ck_sync_q <= 3'h7;
			tlo_sync_q <= 3'h7;
			thi_sync_q <= 3'h7;
			ck_stable_q <= 1'b1;
			tlo_stable_q <= 1'b1;
			thi_stable_q <= 1'b1;
		end
		else if (clk_en)
		begin
			ck_sync_q <= {ck_sync_q[1:0], bus_clock};
			tlo_sync_q <= {tlo_sync_q[1:0], low_strobe_n};
			thi_sync_q <= {thi_sync_q[1:0], debug_serial_pin};
			if (ck_sync_q[1] == ck_sync_q[2])
				ck_stable_q <= ck_sync_q[2];
			if (tlo_sync_q[1] == tlo_sync_q[2])
				tlo_stable_q <= tlo_sync_q[2];
			if (thi_sync_q[1] == thi_sync_q[2])
				thi_stable_q <= thi_sync_q[2];
		end
	end
	assign ck_fall = ck_stable_q && (ck_sync_q[1] == ck_sync_q[2]) && !ck_sync_q[2];

	// Tagging enable and tag latching
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			tagging_q <= 1'b0;
			tag_lo_q <= 1'b0;
			tag_hi_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (bdm_active)
				tagging_q <= 1'b0;
			else if (tagging_enable_command)
				tagging_q <= 1'b1;
			if (ck_fall)
			begin
				tag_lo_q <= tagging_q && !tlo_stable_q;
				tag_hi_q <= tagging_q && !thi_stable_q;
			end
			else if (queue_load || !tagging_q)
			begin
				// A latched tag belongs to one fetch only
				tag_lo_q <= 1'b0;
				tag_hi_q <= 1'b0;
			end
		end
	end
	assign tagging_active = tagging_q;
	assign serial_cmd_allow = !tagging_q;

	// Instruction queue; head at index 0, breakpoint tags kept beside the pin tags
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			queue_count_q <= 2'h0;
			for (int i = 0; i < QUEUE_DEPTH; i++)
			begin
				queue_q[i] <= '0;
				bp_tag_q[i] <= 1'b0;
			end
		end
		else if (clk_en)
		begin
			if (bdm_active)
				queue_count_q <= 2'h0;
			else if (queue_advance && queue_count_q != 2'h0)
			begin
				for (int i = 0; i < QUEUE_DEPTH - 1; i++)
				begin
					queue_q[i] <= queue_q[i + 1];
					bp_tag_q[i] <= bp_tag_q[i + 1];
				end
				queue_q[QUEUE_DEPTH - 1] <= '0;
				bp_tag_q[QUEUE_DEPTH - 1] <= 1'b0;
				if (!queue_load)
					queue_count_q <= queue_count_q - 2'h1;
				else
				begin
					queue_q[queue_count_q - 2'h1] <= qword(cpu_cycle.data, tag_hi_q, tag_lo_q);
					bp_tag_q[queue_count_q - 2'h1] <= bp_tag_in;
				end
			end
			else if (queue_load && queue_count_q != 2'(QUEUE_DEPTH))
			begin
				queue_q[queue_count_q] <= qword(cpu_cycle.data, tag_hi_q, tag_lo_q);
				bp_tag_q[queue_count_q] <= bp_tag_in;
				queue_count_q <= queue_count_q + 2'h1;
			end
		end
	end
	// Pin tags force debug entry when bdm_enable is set; breakpoint tags follow the selected mode
	assign tag_break = (queue_count_q != 2'h0)
		&& (queue_q[0].tag_hi || queue_q[0].tag_lo);
	assign bp_break = (queue_count_q != 2'h0) && bp_tag_q[0];
endmodule

`default_nettype wire

/* File: btu_properties.sv */
// Port checker for the breakpoint and tag unit, bound to btu_top
`timescale 1ns/100ps
`default_nettype none
module btu_checker
	import btu_pkg::*;
(
	input wire logic clk_sys, // clock
	input wire logic rst, // reset
	input wire logic [BUS_ADDR_W-1:0] avs_address, // address
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // lanes
	input wire logic avs_waitrequest, // stall
	input wire logic tagging_enable_command, // tag command
	input wire logic bdm_enable, // debug enable
	input wire logic bdm_active, // debug active
	input wire logic swi_request, // interrupt pulse
	input wire logic bdm_request, // debug pulse
	input wire logic tagging_active, // tagging
	input wire logic serial_cmd_allow // serial allowed
);
	logic [1:0] mode_q;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Mode field as last written by software
	always_ff @(posedge clk_sys or posedge rst)
		if (rst)
			mode_q <= 2'h0;
		else if (avs_write && !avs_waitrequest && avs_byteenable[0]
			&& avs_address[BUS_ADDR_W-1:2] == IDX_CTRL_PRIMARY)
			mode_q <= avs_writedata[7:6];
	a_swi_mode: assert property (swi_request |-> mode_q == MODE_SWI_DUAL)
		else $error("interrupt request outside interrupt mode");
	a_bdm_mode: assert property (bdm_request |-> mode_q[1] || tagging_active)
		else $error("debug request in wrong mode");
	a_bdm_enable: assert property (bdm_request |-> $past(bdm_enable))
		else $error("debug request without enable");
	a_quiet_bdm: assert property (bdm_active [*2] |-> !bdm_request && !swi_request)
		else $error("break while debug active");
	a_one_pulse: assert property ((bdm_request || swi_request)
		|=> !(bdm_request || swi_request))
		else $error("break request longer than one cycle");
	a_tag_start: assert property ($rose(tagging_active)
		|-> $past(tagging_enable_command) || $past(tagging_enable_command, 2))
		else $error("tagging began without command");
	a_tag_stop: assert property ($rose(bdm_active) |-> ##2 !tagging_active)
		else $error("tagging kept after debug entry");
	a_allow_serial: assert property (serial_cmd_allow == !tagging_active)
		else $error("serial commands allowed while tagging");
	a_wait_bound: assert property ((avs_read || avs_write) |-> ##[0:1] !avs_waitrequest)
		else $error("register access stalled too long");
	c_swi: cover property (swi_request);
	c_bdm: cover property (bdm_request);
	c_tag: cover property ($rose(tagging_active));
endmodule
bind btu_top btu_checker chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .tagging_enable_command,
	.bdm_enable, .bdm_active, .swi_request, .bdm_request, .tagging_active,
	.serial_cmd_allow);
`default_nettype wire

/* File: btu_cpu_model.sv */
// CPU bus, instruction queue and debug pod model facing the unit
`timescale 1ns/100ps
`default_nettype none
module btu_cpu_model
	import btu_pkg::*;
(
	input wire logic clk_sys, // clock
	output btu_cycle_s cpu_cycle, // bus cycle
	output logic queue_load, // queue fill
	output logic queue_advance, // queue drain
	output logic bus_clock, // bus clock pin
	output logic low_strobe_n, // low tag pin
	output logic debug_serial_pin // high tag pin
);
	initial
	begin
		cpu_cycle = '0;
		queue_load = 1'h0;
		queue_advance = 1'h0;
		bus_clock = 1'h1;
		low_strobe_n = 1'h1;
		debug_serial_pin = 1'h1;
	end
	task automatic put(input logic [15:0] a, input logic [15:0] d, input logic r, input logic f);
		@(posedge clk_sys);
		cpu_cycle <= '{addr: a, data: d, rd: r, valid: 1'h1, fetch: f};
		queue_load <= f;
		@(posedge clk_sys);
		// Idle bus shows garbage, not the last cycle
		cpu_cycle <= '{addr: ~a, data: ~d, rd: ~r, valid: 1'h0, fetch: 1'h0};
		queue_load <= 1'h0;
	endtask
	task automatic adv;
		@(posedge clk_sys);
		queue_advance <= 1'h1;
		@(posedge clk_sys);
		queue_advance <= 1'h0;
	endtask
	// Tag pins held at hi and lo across one falling bus clock edge
	task automatic tag(input logic hi, input logic lo);
		@(posedge clk_sys);
		debug_serial_pin <= hi;
		low_strobe_n <= lo;
		repeat (4) @(posedge clk_sys);
		bus_clock <= 1'h0;
		repeat (6) @(posedge clk_sys);
		bus_clock <= 1'h1;
		debug_serial_pin <= 1'h1;
		low_strobe_n <= 1'h1;
	endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the breakpoint and tag unit
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import btu_pkg::*;
;
	typedef struct packed {
		logic [7:0] p;
		logic [7:0] s;
		logic [15:0] a;
		logic [15:0] d;
		logic [3:0] e;
	} btu_row_s;
	logic clk_sys, rst, clk_en, avs_read, avs_write, avs_waitrequest;
	logic tagging_enable_command, bdm_enable, bdm_active, swi_request, bdm_request;
	logic tagging_active, serial_cmd_allow, bus_clock, low_strobe_n, debug_serial_pin;
	logic queue_load, queue_advance;
	logic [BUS_ADDR_W-1:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable, nswi, nbdm;
	logic [7:0] q;
	btu_cycle_s cpu_cycle;
	int errors, checks_done;
	// Fields: control, secondary, bus address, bus data, {rd, fetch, swi, bdm}
	btu_row_s rows[19] = '{
		{8'h81,8'h80,16'h1234,16'h5678,4'h9},
		{8'h81,8'h80,16'h1234,16'h5679,4'h8},
		{8'h81,8'hA0,16'h1234,16'h5679,4'h9},
		{8'h81,8'hC0,16'h1234,16'h9978,4'h9},
		{8'h81,8'h00,16'h1234,16'h0000,4'h9},
		{8'h80,8'h00,16'h12FF,16'h0000,4'h9},
		{8'h81,8'h00,16'h12FF,16'h0000,4'h8},
		{8'h01,8'h80,16'h1234,16'h5678,4'h8},
		{8'hC3,8'h80,16'h5678,16'h0000,4'h9},
		{8'hC1,8'h80,16'h56AA,16'h0000,4'h9},
		{8'hC3,8'h80,16'h56AA,16'h0000,4'h8},
		{8'h43,8'h80,16'h1234,16'h0000,4'hE},
		{8'h43,8'h80,16'h1234,16'h0000,4'h8},
		{8'h81,8'h03,16'h1234,16'h5678,4'h0},
		{8'h81,8'h03,16'h1234,16'h0000,4'h9},
		{8'hC3,8'h88,16'h5678,16'h0000,4'h8},
		{8'hC3,8'h88,16'h5678,16'h0000,4'h1},
		{8'hA1,8'h00,16'h1234,16'h0000,4'h8},
		{8'hA1,8'h00,16'h1234,16'h0000,4'hD}
	};
	btu_top dut (.clk_sys, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_cycle,
		.bus_clock, .low_strobe_n, .debug_serial_pin, .tagging_enable_command,
		.bdm_enable, .bdm_active, .queue_load, .queue_advance, .swi_request,
		.bdm_request, .tagging_active, .serial_cmd_allow);
	btu_cpu_model cpu (.clk_sys, .cpu_cycle, .queue_load, .queue_advance, .bus_clock,
		.low_strobe_n, .debug_serial_pin);
	initial
	begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		if (swi_request === 1'h1) nswi <= nswi + 4'h1;
		if (bdm_request === 1'h1) nbdm <= nbdm + 4'h1;
	end
	task automatic conclude;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic c8(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic c4(input string n, input logic [3:0] e, input logic [3:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// One register access; held until waitrequest is sampled low at a rising edge
	task automatic av(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [3:0] be);
		int n;
		@(posedge clk_sys);
		avs_address <= {idx, 2'h0};
		avs_read <= !w;
		avs_write <= w;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (avs_waitrequest !== 1'h0 && n < 20);
		q = avs_readdata[7:0];
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (avs_waitrequest !== 1'h0)
		begin
			errors++;
			$display("[FAIL] waitrequest expected 0 seen %b", avs_waitrequest);
			conclude();
		end
	endtask
	task automatic run(input logic [7:0] p, input logic [7:0] s, input logic [15:0] a,
		input logic [15:0] d, input logic r, input logic f);
		av(1'h1, IDX_CTRL_PRIMARY, p, 4'h1);
		av(1'h1, IDX_CTRL_SECONDARY, s, 4'h1);
		nswi = 4'h0;
		nbdm = 4'h0;
		cpu.put(a, d, r, f);
		repeat (4) cpu.adv();
		repeat (4) @(posedge clk_sys);
	endtask
	initial
	begin
		repeat (100000) @(posedge clk_sys);
		errors++;
		$display("[FAIL] run length expected finish seen timeout");
		conclude();
	end
	initial
	begin
		{rst, clk_en, bdm_enable} = 3'h7;
		{avs_read, avs_write, tagging_enable_command, bdm_active} = 4'h0;
		avs_address = '0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		nswi = 4'h0;
		nbdm = 4'h0;
		errors = 0;
		checks_done = 0;
		repeat (16) @(posedge clk_sys);
		rst <= 1'h0;
		for (logic [7:0] i = 8'h20; i < 8'h26; i++)
		begin
			av(1'h0, i, 8'h00, 4'h0);
			c8("reset value", 8'h00, q);
		end
		av(1'h1, IDX_CTRL_PRIMARY, 8'hE3, 4'h1);
		av(1'h1, IDX_CTRL_PRIMARY, 8'h00, 4'h0);
		av(1'h0, IDX_CTRL_PRIMARY, 8'h00, 4'h0);
		c8("control readback", 8'hE3, q);
		av(1'h0, 8'h30, 8'h00, 4'h0);
		c8("unmapped read", 8'h00, q);
		av(1'h1, IDX_ADDR_HIGH, 8'h12, 4'h1);
		av(1'h1, IDX_ADDR_LOW, 8'h34, 4'h1);
		av(1'h1, IDX_CMP_HIGH, 8'h56, 4'h1);
		av(1'h1, IDX_CMP_LOW, 8'h78, 4'h1);
		$display("register test done");
		foreach (rows[i])
		begin
			run(rows[i].p, rows[i].s, rows[i].a, rows[i].d, rows[i].e[3], rows[i].e[2]);
			c4("swi pulses", {3'h0, rows[i].e[1]}, nswi);
			c4("bdm pulses", {3'h0, rows[i].e[0]}, nbdm);
		end
		av(1'h0, IDX_STATUS, 8'h00, 4'h0);
		c8("status hit", 8'h04, q);
		av(1'h0, IDX_STATUS, 8'h00, 4'h0);
		c8("status cleared", 8'h00, q);
		$display("table test done");
		@(posedge clk_sys);
		tagging_enable_command <= 1'h1;
		@(posedge clk_sys);
		tagging_enable_command <= 1'h0;
		repeat (2) @(posedge clk_sys);
		c4("tagging", 4'h1, {3'h0, tagging_active});
		c4("serial allow", 4'h0, {3'h0, serial_cmd_allow});
		cpu.tag(1'h0, 1'h1);
		run(8'h00, 8'h00, 16'h4000, 16'h0000, 1'h1, 1'h1);
		c4("tag entry", 4'h1, nbdm);
		bdm_active <= 1'h1;
		repeat (3) @(posedge clk_sys);
		c4("tagging off", 4'h0, {3'h0, tagging_active});
		run(8'h81, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0);
		c4("break in debug", 4'h0, nbdm);
		bdm_active <= 1'h0;
		bdm_enable <= 1'h0;
		run(8'h81, 8'h00, 16'h1234, 16'h0000, 1'h1, 1'h0);
		c4("break no enable", 4'h0, nbdm);
		$display("debug test done");
		// Clock enable low must freeze the tagging state
		@(posedge clk_sys);
		clk_en <= 1'h0;
		tagging_enable_command <= 1'h1;
		@(posedge clk_sys);
		tagging_enable_command <= 1'h0;
		repeat (2) @(posedge clk_sys);
		c4("frozen tagging", 4'h0, {3'h0, tagging_active});
		clk_en <= 1'h1;
		// Mid-run reset while tagging is on
		@(posedge clk_sys);
		tagging_enable_command <= 1'h1;
		@(posedge clk_sys);
		tagging_enable_command <= 1'h0;
		@(posedge clk_sys);
		c4("tagging again", 4'h1, {3'h0, tagging_active});
		rst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'h0;
		c4("reset tagging", 4'h0, {3'h0, tagging_active});
		c4("reset serial", 4'h1, {3'h0, serial_cmd_allow});
		av(1'h0, IDX_CTRL_PRIMARY, 8'h00, 4'h0);
		c8("reset control", 8'h00, q);
		$display("reset test done");
		conclude();
	end
endmodule
`default_nettype wire
